//--- logic/rss_apb_slave.sv
// APB slave front end: one wait-free access phase, registered answer
module rss_apb_slave (
	input  wire logic   clk,
	input  wire logic   reset,
	input  wire logic   psel,
	input  wire logic   penable,
	input  wire logic   pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic        pready,
	output logic [31:0] prdata,
	output logic        pslverr,
	rss_reg_if.slave    rif
);
	logic addr_ok;
	logic setup;

	// Word aligned and inside the index window only
	assign addr_ok   = (paddr[1:0] == 2'h0) && (paddr[31:10] == 22'h0);
	assign rif.index = paddr[9:2];
	assign rif.wdata = pwdata;
	assign rif.wstrb = pstrb;
	assign setup     = psel && !penable;
	// Write lands only on the completing access edge
	assign rif.wr_en = psel && penable && pready && pwrite && addr_ok && rif.hit;

	// Answer one cycle after setup so the access phase is exactly one cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			pready <= 1'b0;
		end else begin
			pready <= setup;
		end
	end

	// Read data and error are captured in setup and held through access
	always_ff @(posedge clk) begin
		if (reset) begin
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata  <= (!pwrite && addr_ok && rif.hit) ? rif.rdata : 32'h0;
			pslverr <= !(addr_ok && rif.hit);
		end else if (!psel) begin
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end
	end
endmodule : rss_apb_slave

//--- logic/rss_pkg.sv
// Package: strap index map, field positions, decode tables for the strap sampler
package rss_pkg;

	// Strap register indices; byte address is four times the index
	localparam logic [7:0] IDX_MODULE_LOW  = 8'h4A;
	localparam logic [7:0] IDX_MODULE_HIGH = 8'h4B;
	localparam logic [7:0] IDX_BUS_CLOCK   = 8'h4C;
	localparam logic [7:0] IDX_HOST_PLL    = 8'h5F;
	localparam logic [7:0] IDX_CORE_CLOCK  = 8'h60;
	localparam logic [7:0] IDX_STATUS      = 8'h61;

	// Strap line count and line positions
	localparam int          STRAP_LINES     = 44;
	localparam int          LOW_BASE        = 0;
	localparam int          HIGH_BASE       = 8;
	localparam int          BUS_LOW_BASE    = 16;
	localparam int          BUS_LOW_WIDTH   = 5;
	localparam int          BUS_TOP_LINE    = 23;
	localparam int          PLL_BASE        = 21;
	localparam int          PLL_WIDTH       = 6;
	localparam int          PIN_FUNC_LINE   = 0;
	localparam int          PCI_DIV_LINE    = 17;
	localparam int          CORE_MULT_LINE  = 40;

	// Field positions inside the registers
	localparam int          BUS_WR_BIT      = 4;
	localparam int          BUS_TOP_BIT     = 5;
	localparam int          PCI_DIV_BIT     = 1;
	localparam int          PLL_CODE_LSB    = 3;
	localparam int          PLL_CODE_W      = 3;
	localparam int          TYPE_HI_BIT     = 7;
	localparam int          TYPE_LO_BIT     = 4;

	// Expected board pull levels of reserved lines, and which lines are reserved
	localparam logic [43:0] RSVD_MASK       = 44'hEFF_F8FD_0102;
	localparam logic [43:0] RSVD_EXPECT     = 44'h4F0_00FD_0100;

	// Divider settings for the PCI clock enable
	localparam logic [1:0]  PCI_DIV_TWO     = 2'h1;
	localparam logic [1:0]  PCI_DIV_THREE   = 2'h2;

	// Speed and type encodings per strap bit
	localparam logic        SPEED_70NS      = 1'h0;
	localparam logic        SPEED_60NS      = 1'h1;
	localparam logic        TYPE_EXT_DATA   = 1'h0;
	localparam logic        TYPE_FAST_PAGE  = 1'h1;
	localparam int          SPEED_SLOW_NS   = 70;
	localparam int          SPEED_FAST_NS   = 60;

	// Host synthesizer frequency per code, in MHz
	typedef logic [6:0] rss_mhz_t;
	localparam rss_mhz_t PLL_MHZ [8] = '{7'h19, 7'h21, 7'h28, 7'h32, 7'h3C, 7'h42, 7'h4B, 7'h50};

endpackage : rss_pkg

//--- logic/rss_reg_if.sv
// Interface: register access between the bus slave and the strap register file
interface rss_reg_if;
	logic [7:0]  index;
	logic        wr_en;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic [31:0] rdata;
	logic        hit;

	modport slave (output index, output wr_en, output wdata, output wstrb,
	               input rdata, input hit);
	modport regs  (input index, input wr_en, input wdata, input wstrb,
	               output rdata, output hit);
endinterface : rss_reg_if

//--- logic/rss_top.sv
// Top: strap line sampling at reset release, strap registers and derived clock controls

// How it works
// RL1: Low module register mirrors lines seven to zero
// RL2: High module register mirrors lines fifteen to eight
// RL3: Registers load sampled strap levels at reset
// RL4: Module speed/type bits only readable, no control
// RL5: Speed bit low 70ns, high 60ns
// RL6: Type bit selects extended_data_out or fast_page_mode
// RL7: Line zero picks colour key or memory write
// RL8: Line seventeen picks PCI clock divide two/three
// RL9: Lines 26-24 select host synthesizer frequency
// RL10: Only bit four of bus clock register writable
// RL11: Line forty sets core clock one or two
// RL12: Capture once at release, hold until reset
// RL13: Board holds reserved lines at fixed pulls
module rss_top (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic [43:0] mem_data_strap_line,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	output logic             straps_valid,
	output logic             shared_pin_isa_write,
	output logic             pci_clock_div_three,
	output logic             pci_clock_out,
	output logic             pci_clock_tick,
	output logic [2:0]       host_pll_code,
	output logic [6:0]       host_pll_mhz,
	output logic             core_clock_times_one,
	output logic             core_clock_times_two,
	output logic             reserved_mismatch
);

	rss_reg_if rif ();

	logic [43:0] strap_meta;
	logic [43:0] strap_sync;
	logic        reset_seen;
	logic        capture;
	logic        captured;

	logic [7:0]  strap_module_low;
	logic [7:0]  strap_module_high;
	logic [7:0]  strap_bus_clock;
	logic [7:0]  strap_host_pll;
	logic        core_mult;
	logic [43:0] strap_raw;

	logic [1:0]  pci_count;
	logic [1:0]  pci_limit;
	logic [43:0] rsvd_diff;
	logic        next_mismatch;
	logic [31:0] next_rdata;
	logic        next_hit;

	// Bus front end; the register file below answers its index lookups
	rss_apb_slave rss_apb_slave_inst (
		.clk     (clk),
		.reset   (reset),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.pstrb   (pstrb),
		.pready  (pready),
		.prdata  (prdata),
		.pslverr (pslverr),
		.rif     (rif)
	);

	// Pin synchroniser; left unreset so it keeps tracking the board pulls
	// through reset and is settled by the time reset is released
	always_ff @(posedge clk) begin
		strap_meta <= mem_data_strap_line;
	end

	// Second stage; the only reader of the first stage
	always_ff @(posedge clk) begin
		strap_sync <= strap_meta;
	end

	// Remember that reset was high on the previous edge
	always_ff @(posedge clk) begin
		reset_seen <= reset;
	end

	// One-cycle capture strobe in the first cycle after release
	assign capture = reset_seen && !reset; // RL12

	// Capture flag; once set it blocks any further sampling until reset
	always_ff @(posedge clk) begin
		if (reset) begin
			captured <= 1'b0;
		end else if (capture) begin
			captured <= 1'b1; // RL12
		end
	end

	// Raw image of every strap line, kept for the reserved-line check
	always_ff @(posedge clk) begin
		if (reset) begin
			strap_raw <= 44'h0;
		end else if (capture && !captured) begin
			strap_raw <= strap_sync; // RL3 RL12
		end
	end

	// Module straps: pure mirrors of the lines, never fed to any memory
	// controller logic here; software reads them and programs timing itself
	always_ff @(posedge clk) begin
		if (reset) begin
			strap_module_low  <= 8'h0;
			strap_module_high <= 8'h0;
		end else if (capture && !captured) begin
			strap_module_low  <= strap_sync[rss_pkg::LOW_BASE +: 8];  // RL1 RL3 RL4 RL5 RL6
			strap_module_high <= strap_sync[rss_pkg::HIGH_BASE +: 8]; // RL2 RL3 RL4 RL5 RL6
		end
	end

	// Bus clock straps: bits 4-0 from lines 20-16, bit 5 from line 23.
	// Bit 4 also takes software writes; the rest ignore them.
	always_ff @(posedge clk) begin
		if (reset) begin
			strap_bus_clock <= 8'h0;
		end else if (capture && !captured) begin
			strap_bus_clock[rss_pkg::BUS_LOW_WIDTH-1:0] <=
				strap_sync[rss_pkg::BUS_LOW_BASE +: rss_pkg::BUS_LOW_WIDTH]; // RL3
			strap_bus_clock[rss_pkg::BUS_TOP_BIT] <= strap_sync[rss_pkg::BUS_TOP_LINE];
			strap_bus_clock[7:6] <= 2'h0;
		end else if (rif.wr_en && rif.index == rss_pkg::IDX_BUS_CLOCK && rif.wstrb[0]) begin
			strap_bus_clock[rss_pkg::BUS_WR_BIT] <= rif.wdata[rss_pkg::BUS_WR_BIT]; // RL10
		end
	end

	// Host synthesizer straps: bits 5-0 from lines 26-21
	always_ff @(posedge clk) begin
		if (reset) begin
			strap_host_pll <= 8'h0;
		end else if (capture && !captured) begin
			strap_host_pll[rss_pkg::PLL_WIDTH-1:0] <=
				strap_sync[rss_pkg::PLL_BASE +: rss_pkg::PLL_WIDTH]; // RL3 RL9
			strap_host_pll[7:6] <= 2'h0;
		end
	end

	// Core clock multiplier strap
	always_ff @(posedge clk) begin
		if (reset) begin
			core_mult <= 1'b0;
		end else if (capture && !captured) begin
			core_mult <= strap_sync[rss_pkg::CORE_MULT_LINE]; // RL11
		end
	end

	// Lines that the board should hold at a fixed pull, compared with the
	// expected level; a mismatch points at a board fault, not at this logic
	assign rsvd_diff     = (strap_raw ^ rss_pkg::RSVD_EXPECT) & rss_pkg::RSVD_MASK; // RL13
	assign next_mismatch = captured && (rsvd_diff != 44'h0);

	// Status view for software and the clock logic
	always_ff @(posedge clk) begin
		if (reset) begin
			straps_valid      <= 1'b0;
			reserved_mismatch <= 1'b0;
		end else begin
			straps_valid      <= captured;
			reserved_mismatch <= next_mismatch;
		end
	end

	// Shared pin routing: low selects colour key, high selects memory write
	always_ff @(posedge clk) begin
		if (reset) begin
			shared_pin_isa_write <= 1'b0;
		end else begin
			shared_pin_isa_write <= strap_module_low[rss_pkg::PIN_FUNC_LINE]; // RL7
		end
	end

	// Core multiplier outputs, exactly one of them high once captured
	always_ff @(posedge clk) begin
		if (reset) begin
			core_clock_times_one <= 1'b0;
			core_clock_times_two <= 1'b0;
		end else begin
			core_clock_times_one <= captured && !core_mult; // RL11
			core_clock_times_two <= captured && core_mult;  // RL11
		end
	end

	// Host synthesizer code and its frequency from the table
	always_ff @(posedge clk) begin
		if (reset) begin
			host_pll_code <= 3'h0;
			host_pll_mhz  <= 7'h0;
		end else begin
			host_pll_code <= strap_host_pll[rss_pkg::PLL_CODE_LSB +: rss_pkg::PLL_CODE_W]; // RL9
			host_pll_mhz  <= rss_pkg::PLL_MHZ[strap_host_pll[rss_pkg::PLL_CODE_LSB +:
				rss_pkg::PLL_CODE_W]]; // RL9
		end
	end

	// PCI divisor select: low divides by two, high by three
	assign pci_limit = strap_bus_clock[rss_pkg::PCI_DIV_BIT] ?
		rss_pkg::PCI_DIV_THREE : rss_pkg::PCI_DIV_TWO; // RL8

	// Divider counter; held until the straps are known so the first PCI
	// period never runs at a guessed rate
	always_ff @(posedge clk) begin
		if (reset || !captured) begin
			pci_count <= 2'h0;
		end else if (pci_count >= pci_limit) begin
			pci_count <= 2'h0; // RL8
		end else begin
			pci_count <= pci_count + 2'h1;
		end
	end

	// PCI clock image and enable pulse; one clk high per divided period,
	// so the divide-by-three output is not of equal duty
	always_ff @(posedge clk) begin
		if (reset) begin
			pci_clock_out       <= 1'b0;
			pci_clock_tick      <= 1'b0;
			pci_clock_div_three <= 1'b0;
		end else begin
			pci_clock_out       <= captured && (pci_count == 2'h0);
			pci_clock_tick      <= captured && (pci_count >= pci_limit);
			pci_clock_div_three <= strap_bus_clock[rss_pkg::PCI_DIV_BIT]; // RL8
		end
	end

	// Read lookup; the slave registers the result, reserved bits read zero
	always_comb begin
		next_rdata = 32'h0;
		next_hit   = 1'b1;
		case (rif.index)
			rss_pkg::IDX_MODULE_LOW: begin
				next_rdata[7:0] = strap_module_low;  // RL1 RL4
			end
			rss_pkg::IDX_MODULE_HIGH: begin
				next_rdata[7:0] = strap_module_high; // RL2 RL4
			end
			rss_pkg::IDX_BUS_CLOCK: begin
				next_rdata[7:0] = strap_bus_clock;
			end
			rss_pkg::IDX_HOST_PLL: begin
				next_rdata[7:0] = strap_host_pll;
			end
			rss_pkg::IDX_CORE_CLOCK: begin
				next_rdata[0] = core_mult;
			end
			rss_pkg::IDX_STATUS: begin
				next_rdata[0] = captured;
				next_rdata[1] = next_mismatch;
			end
			default: begin
				next_hit = 1'b0;
			end
		endcase
	end

	assign rif.rdata = next_rdata;
	assign rif.hit   = next_hit;

endmodule : rss_top

//--- sim/reset_strap_sampler_test.sv
// Testbench: strap capture, register reads, write mask and refused addresses
module reset_strap_sampler_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd, v;
	logic [3:0]  pstrb = 4'h0;
	logic [43:0] pattern = 44'h0, lines, p;
	logic        pready, pslverr, valid, isa_wr, div3, pci_out, tick, one, two, mism, err;
	logic [2:0]  code;
	logic [6:0]  mhz;
	logic [6:0]  mhz_tab [8] = '{7'h19, 7'h21, 7'h28, 7'h32, 7'h3C, 7'h42, 7'h4B, 7'h50};
	int          fail_count = 0;
	int          samples_checked = 0;
	always #4 clk = ~clk;
	rss_board rss_board_inst (.clk(clk), .reset(reset), .pattern(pattern),
		.mem_data_strap_line(lines));
	rss_top rss_top_inst (.clk(clk), .reset(reset), .mem_data_strap_line(lines), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .straps_valid(valid),
		.shared_pin_isa_write(isa_wr), .pci_clock_div_three(div3), .pci_clock_out(pci_out),
		.pci_clock_tick(tick), .host_pll_code(code), .host_pll_mhz(mhz),
		.core_clock_times_one(one), .core_clock_times_two(two), .reserved_mismatch(mism));
	task automatic final_report();
		if (fail_count == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	// One APB transfer; waits for ready under a bound, never a fixed count
	task automatic apb(input logic w, input logic [31:0] a, d, output logic [31:0] r,
		output logic e);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= 4'hF;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			fail_count++;
			$display("Error at %0t: ready got %h expected %h", $time, pready, 1'b1);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Reset held five cycles, then time for capture and for the board to move
	task automatic do_reset(input logic [43:0] q);
		pattern <= q;
		reset <= 1'b1;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		repeat (8) @(posedge clk);
	endtask : do_reset
	task automatic test_capture(input logic [3:0] n);
		int k;
		// Second speed bit of each pair is pulled high on the board
		p = (rss_pkg::RSVD_EXPECT & rss_pkg::RSVD_MASK) | ({11{n}} & ~rss_pkg::RSVD_MASK)
			| 44'h000_0000_4848;
		do_reset(p);
		apb(1'b0, 32'h128, 32'h0, rd, err);
		chk(rd, {24'h0, p[7:0]});
		apb(1'b0, 32'h12C, 32'h0, rd, err);
		chk(rd, {24'h0, p[15:8]});
		apb(1'b0, 32'h130, 32'h0, rd, err);
		chk(rd, {26'h0, p[23], p[20:16]});
		apb(1'b0, 32'h17C, 32'h0, rd, err);
		chk(rd, {26'h0, p[26:21]});
		apb(1'b0, 32'h180, 32'h0, rd, err);
		chk(rd, {31'h0, p[40]});
		chk({27'h0, isa_wr, div3, one, two, mism}, {27'h0, p[0], p[17], !p[40], p[40], 1'b0});
		chk({22'h0, code, mhz}, {22'h0, p[26:24], mhz_tab[p[26:24]]});
		// Six cycles hold three divide-by-two or two divide-by-three pulses
		k = 0;
		repeat (6) begin
			@(posedge clk);
			if (pci_out === 1'b1)
				k++;
		end
		chk(32'(k), p[17] ? 32'h2 : 32'h3);
	endtask : test_capture
	// Only bit four takes a write; module straps ignore writes without error
	task automatic test_write();
		apb(1'b0, 32'h130, 32'h0, v, err);
		apb(1'b1, 32'h130, ~v, rd, err);
		chk({31'h0, err}, 32'h0);
		apb(1'b0, 32'h130, 32'h0, rd, err);
		chk(rd, v ^ 32'h10);
		apb(1'b0, 32'h128, 32'h0, v, err);
		apb(1'b1, 32'h128, 32'hFF, rd, err);
		chk({31'h0, err}, 32'h0);
		apb(1'b0, 32'h128, 32'h0, rd, err);
		chk({rd[30:0], err}, {v[30:0], 1'b0});
	endtask : test_write
	// Unmapped and misaligned places are refused with zero data, one after another
	task automatic test_bad();
		logic [31:0] bad [3] = '{32'h100, 32'h129, 32'h400};
		foreach (bad[i]) begin
			apb(1'b0, bad[i], 32'h0, rd, err);
			chk({rd[30:0], err}, 32'h1);
		end
	endtask : test_bad
	// A reserved line off its pull is flagged in the status word
	task automatic test_mismatch();
		do_reset((rss_pkg::RSVD_EXPECT & rss_pkg::RSVD_MASK) ^ 44'h2);
		apb(1'b0, 32'h184, 32'h0, rd, err);
		chk({rd[30:0], mism}, 32'h7);
	endtask : test_mismatch
	initial begin
		for (int i = 0; i < 16; i++)
			test_capture(4'(i));
		test_write();
		test_bad();
		test_mismatch();
		final_report();
	end
	// Watchdog well beyond the expected run of about 590 cycles
	initial begin
		#100000;
		fail_count++;
		final_report();
	end
endmodule : reset_strap_sampler_test

//--- sim/rss_board.sv
// Board model: strap pull resistors, with user lines moving after capture
module rss_board (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic [43:0] pattern,
	output logic      [43:0] mem_data_strap_line
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] settle;
	// Cycles since release; user lines flip once capture is long over and stay flipped
	always_ff @(posedge clk) begin
		if (reset)
			settle <= 3'h0;
		else if (settle != 3'h7)
			settle <= settle + 3'h1;
	end
	// Reserved lines never move, so later activity cannot fake a mismatch
	assign mem_data_strap_line = pattern ^ ({44{settle > 3'h3}} & ~rss_pkg::RSVD_MASK);
endmodule : rss_board

//--- sim/rss_top_sva.sv
// Checker: bus answer timing and strap output relations of the strap sampler
module rss_top_sva (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        straps_valid,
	input wire logic        pci_clock_tick,
	input wire logic        pci_clock_div_three,
	input wire logic        core_clock_times_one,
	input wire logic        core_clock_times_two,
	input wire logic [31:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic [2:0]  host_pll_code,
	input wire logic [6:0]  host_pll_mhz
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// Tick spacing of the two divisors
	sequence seq_div2; !pci_clock_tick ##1 pci_clock_tick; endsequence
	sequence seq_div3; !pci_clock_tick [*2] ##1 pci_clock_tick; endsequence
	chk_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	chk_ready_single: assert property (pready |=> !pready)
		else $error("ready held too long");
	chk_err_bad_addr: assert property (psel && !penable
		&& (paddr[1:0] != 2'h0 || paddr[31:10] != 22'h0) |=> pslverr && prdata == 32'h0)
		else $error("bad address not refused");
	// Outputs clear on the edge that sees psel low, so look one cycle later
	chk_idle_quiet: assert property (!psel |=> prdata == 32'h0 && !pslverr)
		else $error("bus outputs not cleared");
	chk_valid_start: assert property ($fell(reset) |-> !straps_valid ##2 straps_valid)
		else $error("capture timing wrong");
	chk_valid_hold: assert property (straps_valid |=> straps_valid && $stable(host_pll_code)
		&& $stable(core_clock_times_two) && $stable(pci_clock_div_three))
		else $error("captured value moved");
	chk_pll_table: assert property (straps_valid |-> host_pll_mhz == rss_pkg::PLL_MHZ[host_pll_code])
		else $error("synthesizer frequency wrong");
	chk_core_mult: assert property (straps_valid |-> core_clock_times_one != core_clock_times_two)
		else $error("core multiplier not exclusive");
	chk_pci_half: assert property (pci_clock_tick && !pci_clock_div_three |=> seq_div2)
		else $error("divide by two spacing wrong");
	chk_pci_third: assert property (pci_clock_tick && pci_clock_div_three |=> seq_div3)
		else $error("divide by three spacing wrong");
	chk_reset_clear: assert property (disable iff (1'b0) reset |=> !straps_valid && !pready)
		else $error("outputs live in reset");
endmodule : rss_top_sva

bind rss_top rss_top_sva rss_top_sva_inst (.clk(clk), .reset(reset), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .straps_valid(straps_valid),
	.pci_clock_tick(pci_clock_tick), .pci_clock_div_three(pci_clock_div_three),
	.core_clock_times_one(core_clock_times_one), .core_clock_times_two(core_clock_times_two),
	.paddr(paddr), .prdata(prdata), .host_pll_code(host_pll_code), .host_pll_mhz(host_pll_mhz));
